// ==== hw/dtcl_loader.sv ====
// Chain loading end: channel parameters, pointer, arbitration and block fetch
`timescale 1ns/10ps
`include "dtcl_cfg.svh"
module dtcl_loader
    import dtcl_pkg::*;
#(
    parameter int NCH    = 10,
    parameter int CW     = 4,
    parameter int EXT_CH = `DTCL_FIRST_EXT_CH
) (
    input  wire logic            clk,
    input  wire logic            rst_b,
    dtcl_if.dev                  bus,
    input  wire logic [NCH-1:0]  seq_done,
    input  wire logic [NCH-1:0]  xfer_req,
    input  wire logic [NCH-1:0]  two_d_en,
    input  wire logic [NCH-1:0]  link_tx,
    input  wire logic            mesh_route_enable,
    input  wire logic [CW-1:0]   rd_ch,
    input  wire logic [3:0]      rd_slot,
    output logic      [NCH-1:0]  xfer_gnt,
    output logic      [NCH-1:0]  chan_active,
    output logic                 loading,
    output logic      [31:0]     rd_data
);

    // Whole state of the loader in one record
    typedef struct packed {
        dtcl_ld_t                              ld;        // Fetch sequencer
        logic [CW-1:0]                         ch;        // Channel being loaded
        logic [3:0]                            idx;       // Word index below pointer
        logic [`DTCL_ADDR_W-1:0]               work;      // Hidden working address
        logic [NCH-1:0]                        chain_en;  // Chain enable per channel
        logic [NCH-1:0]                        chan_en;   // Channel enable per channel
        logic [NCH-1:0]                        active;    // Sequence under way
        logic [NCH-1:0]                        pend;      // Latched block load request
        logic [NCH-1:0]                        irq;       // Interrupt pulses
        logic [NCH-1:0][17:0]                  cp;        // Chain pointers
        logic [NCH-1:0][`DTCL_SLOTS-1:0][31:0] prm;       // Parameter slots
        logic                                  mem_req;   // Read request pulse
        logic [17:0]                           mem_addr;  // Read address
        logic [31:0]                           rd_data;   // Read-back data
    } dtcl_st_t;

    dtcl_st_t        st_r;      // Registered state
    dtcl_st_t        st_nxt;    // Next state
    logic [NCH-1:0]  gnt_c;     // Data grant, combinational
    logic [NCH-1:0]  req_c;     // Requests taking part in arbitration
    logic [CW-1:0]   win_c;     // Winning channel
    logic            any_c;     // Some request present
    logic [3:0]      last_c;    // Last word index of the loading channel
    logic            ser_c;     // Loading channel is serial or link 0..3
    logic [CW-1:0]   sc;        // Channel addressed by software

    assign sc = bus.sw_ch;

    // Last word index depends on channel kind and options
    function automatic logic [3:0] last_idx(input int c, input logic td, input logic lt,
                                            input logic mesh);
        if (c >= EXT_CH)
            return `DTCL_LAST_EXT;
        else if (lt && mesh)
            return `DTCL_LAST_MESH;
        else if (td)
            return `DTCL_LAST_2D;
        else
            return `DTCL_LAST_BASE;
    endfunction

    // Next state: software writes, sequence ends, arbitration, word fetch
    always_comb begin
        st_nxt   = st_r;
        st_nxt.irq     = '0;
        st_nxt.mem_req = 1'b0;
        gnt_c    = '0;
        req_c    = '0;
        win_c    = '0;
        any_c    = 1'b0;
        ser_c    = (int'(st_r.ch) < EXT_CH);
        last_c   = last_idx(int'(st_r.ch), two_d_en[st_r.ch], link_tx[st_r.ch],
                            mesh_route_enable);

        // Software register writes
        if (bus.sw_wr) begin
            case (bus.sw_reg)
                `DTCL_REG_CTRL: begin
                    st_nxt.chain_en[sc] = bus.sw_data[`DTCL_CTRL_CHAIN];
                    st_nxt.chan_en[sc]  = bus.sw_data[`DTCL_CTRL_ENABLE];
                    // Unchained channels start and stop on the enable alone
                    if (!bus.sw_data[`DTCL_CTRL_CHAIN]) begin
                        if (bus.sw_data[`DTCL_CTRL_ENABLE] && !st_r.chan_en[sc])
                            st_nxt.active[sc] = 1'b1;
                        else if (!bus.sw_data[`DTCL_CTRL_ENABLE])
                            st_nxt.active[sc] = 1'b0;
                    end
                    // Clearing only the enable keeps the sequence running
                end
                `DTCL_SLOT_CP: begin
                    st_nxt.cp[sc] = bus.sw_data[17:0];
                    // A nonzero address field on an idle chained channel starts a block load
                    if (st_r.chain_en[sc] && st_r.chan_en[sc] && !st_r.active[sc]
                        && !(st_r.ld != LD_IDLE && st_r.ch == sc)
                        && bus.sw_data[`DTCL_ADDR_W-1:0] != '0)
                        st_nxt.pend[sc] = 1'b1;
                end
                default: begin
                    // Direct parameter writes, also the way a block is inserted
                    if (bus.sw_reg < 4'(`DTCL_SLOTS))
                        st_nxt.prm[sc][bus.sw_reg] = bus.sw_data;
                end
            endcase
        end

        // End of a sequence decides interrupt and next block
        for (int i = 0; i < NCH; i++) begin
            if (seq_done[i] && st_r.active[i]) begin
                st_nxt.active[i] = 1'b0;
                if (st_r.chain_en[i] && !st_r.chan_en[i]) begin
                    st_nxt.irq[i] = 1'b1;
                end else if (st_r.chain_en[i]) begin
                    st_nxt.irq[i] = st_r.cp[i][`DTCL_PCI_BIT];
                    if (st_r.cp[i][`DTCL_ADDR_W-1:0] != '0)
                        st_nxt.pend[i] = 1'b1;
                end else begin
                    st_nxt.irq[i] = 1'b1;
                end
            end
        end

        // Requests: running load word, latched loads when none runs, data words
        for (int i = 0; i < NCH; i++) begin
            req_c[i] = (st_r.ld == LD_ISSUE && int'(st_r.ch) == i)
                     || (st_r.ld == LD_IDLE && st_r.pend[i])
                     || (xfer_req[i] && st_r.active[i]);
        end

        // Lowest channel number wins; the bus is busy while a word is in flight
        if (st_r.ld != LD_WAIT) begin
            for (int i = NCH - 1; i >= 0; i--) begin
                if (req_c[i]) begin
                    win_c = CW'(i);
                    any_c = 1'b1;
                end
            end
        end

        // Grant: a block word read or a data word
        if (any_c) begin
            if (st_r.ld == LD_IDLE && st_r.pend[win_c]) begin
                // Working address copied before the first word
                st_nxt.ch        = win_c;
                st_nxt.idx       = 4'h0;
                st_nxt.work      = st_r.cp[win_c][`DTCL_ADDR_W-1:0];
                st_nxt.pend[win_c] = 1'b0;
                st_nxt.mem_addr  = {1'b0, st_r.cp[win_c][`DTCL_ADDR_W-1:0]}
                                   + `DTCL_MEM_OFFSET;
                st_nxt.mem_req   = 1'b1;
                st_nxt.ld        = LD_WAIT;
            end else if (st_r.ld == LD_ISSUE && win_c == st_r.ch) begin
                st_nxt.mem_addr  = {1'b0, st_r.work} + `DTCL_MEM_OFFSET;
                st_nxt.mem_req   = 1'b1;
                st_nxt.ld        = LD_WAIT;
            end else begin
                gnt_c[win_c] = 1'b1;
            end
        end

        // Word returned: store it, step the working address down
        if (st_r.ld == LD_WAIT && bus.mem_rvalid) begin
            if (st_r.idx == `DTCL_SLOT_CP) begin
                st_nxt.cp[st_r.ch] = bus.mem_rdata[17:0];
            end else if (!(ser_c && st_r.idx == `DTCL_SLOT_DB && !two_d_en[st_r.ch])) begin
                // Second count is skipped in 1D but its word is still passed over
                st_nxt.prm[st_r.ch][st_r.idx] = bus.mem_rdata;
            end
            if (ser_c && st_r.idx == `DTCL_SLOT_CNT && two_d_en[st_r.ch])
                st_nxt.prm[st_r.ch][`DTCL_SLOT_DA] = bus.mem_rdata;
            st_nxt.work = st_r.work - `DTCL_ADDR_W'(1);
            if (st_r.idx == last_c) begin
                // Loop-back chains work because the hidden copy takes the new pointer
                st_nxt.work = st_nxt.cp[st_r.ch][`DTCL_ADDR_W-1:0];
                st_nxt.active[st_r.ch] = 1'b1;
                st_nxt.ld = LD_IDLE;
            end else begin
                st_nxt.idx = st_r.idx + 4'h1;
                st_nxt.ld  = LD_ISSUE;
            end
        end

        // Read-back port; the working address has no path here
        if (rd_slot == `DTCL_SLOT_CP)
            st_nxt.rd_data = {14'h0000, st_r.cp[rd_ch]};
        else if (rd_slot < 4'(`DTCL_SLOTS))
            st_nxt.rd_data = st_r.prm[rd_ch][rd_slot];
        else
            st_nxt.rd_data = 32'h0000_0000;
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign xfer_gnt     = gnt_c;
    assign chan_active  = st_r.active;
    assign loading      = (st_r.ld != LD_IDLE);
    assign rd_data      = st_r.rd_data;
    assign bus.mem_req  = st_r.mem_req;
    assign bus.mem_addr = st_r.mem_addr;
    assign bus.irq      = st_r.irq;

endmodule

// ==== hw/dtcl_cfg.svh ====
// Constants of the transfer control block chain loader
`ifndef DTCL_CFG_SVH
`define DTCL_CFG_SVH
`define DTCL_MEM_OFFSET   18'h20000
`define DTCL_ADDR_W       17
`define DTCL_PCI_BIT      17
`define DTCL_CP_RESET     18'h00000
`define DTCL_SLOTS        10
`define DTCL_SLOT_II      4'h0
`define DTCL_SLOT_CNT     4'h2
`define DTCL_SLOT_CP      4'h3
`define DTCL_SLOT_DB      4'h5
`define DTCL_SLOT_DA      4'h9
`define DTCL_REG_CTRL     4'ha
`define DTCL_LAST_EXT     4'h7
`define DTCL_LAST_BASE    4'h4
`define DTCL_LAST_2D      4'h5
`define DTCL_LAST_MESH    4'h8
`define DTCL_CTRL_CHAIN   1
`define DTCL_CTRL_ENABLE  0
`define DTCL_FIRST_EXT_CH 6
`endif

// ==== hw/dtcl_pkg.sv ====
// Types shared by both ends of the chain loader
`include "dtcl_cfg.svh"
package dtcl_pkg;
    typedef logic [3:0] dtcl_slot_t;                 // Parameter slot or control select
    typedef logic [17:0] dtcl_cp_t;                  // Interrupt bit plus address field
    typedef enum logic [1:0] {
        LD_IDLE,                                     // No block being fetched
        LD_ISSUE,                                    // Next word waits for the bus
        LD_WAIT                                      // Word read in flight
    } dtcl_ld_t;
endpackage

// ==== hw/dtcl_if.sv ====
// Carrier between the chain loader and its software and memory side
`timescale 1ns/10ps
interface dtcl_if #(
    parameter int NCH = 10,
    parameter int CW  = 4
);
    logic             sw_wr;       // One-cycle register write strobe
    logic [CW-1:0]    sw_ch;       // Channel written
    logic [3:0]       sw_reg;      // Slot or control select
    logic [31:0]      sw_data;     // Write data
    logic             mem_req;     // One-cycle internal memory read request
    logic [17:0]      mem_addr;    // Internal memory word address
    logic             mem_rvalid;  // Read data valid, one cycle
    logic [31:0]      mem_rdata;   // Read data
    logic [NCH-1:0]   irq;         // Sequence completion interrupt pulses

    modport dev (
        input  sw_wr,
        input  sw_ch,
        input  sw_reg,
        input  sw_data,
        input  mem_rvalid,
        input  mem_rdata,
        output mem_req,
        output mem_addr,
        output irq
    );
    modport sw (
        output sw_wr,
        output sw_ch,
        output sw_reg,
        output sw_data,
        output mem_rvalid,
        output mem_rdata,
        input  mem_req,
        input  mem_addr,
        input  irq
    );
endinterface

// ==== hw/dtcl_soft.sv ====
// Software and internal memory end: register writes and block storage
`timescale 1ns/10ps
`include "dtcl_cfg.svh"
module dtcl_soft
    import dtcl_pkg::*;
#(
    parameter int NCH   = 10,
    parameter int CW    = 4,
    parameter int WORDS = 256,
    parameter int AW    = 8
) (
    input  wire logic            clk,
    input  wire logic            rst_b,
    dtcl_if.sw                   bus,
    input  wire logic            cmd_valid,
    input  wire logic [CW-1:0]   cmd_ch,
    input  wire logic [3:0]      cmd_reg,
    input  wire logic [31:0]     cmd_data,
    input  wire logic            cmd_pci,
    input  wire logic            mem_wr,
    input  wire logic [AW-1:0]   mem_wr_addr,
    input  wire logic [31:0]     mem_wr_data,
    output logic      [NCH-1:0]  irq_seen
);

    // Whole state of this end in one record
    typedef struct packed {
        logic                       sw_wr;     // Write strobe
        logic [CW-1:0]              sw_ch;     // Channel
        logic [3:0]                 sw_reg;    // Register select
        logic [31:0]                sw_data;   // Write data
        logic                       rvalid;    // Read answer valid
        logic [31:0]                rdata;     // Read answer
        logic [NCH-1:0]             irq_seen;  // Sticky interrupts
        logic [WORDS-1:0][31:0]     mem;       // Block storage
    } dtcl_sw_t;

    dtcl_sw_t        st_r;     // Registered state
    dtcl_sw_t        st_nxt;   // Next state
    logic [17:0]     rel_c;    // Address relative to the memory base

    // Next state: command forwarding, memory preload and read answer
    always_comb begin
        st_nxt        = st_r;
        st_nxt.sw_wr  = cmd_valid;
        st_nxt.rvalid = 1'b0;
        rel_c         = bus.mem_addr - `DTCL_MEM_OFFSET;
        if (cmd_valid) begin
            st_nxt.sw_ch  = cmd_ch;
            st_nxt.sw_reg = cmd_reg;
            // Pointer writes keep only the address field; interrupt bit joined apart
            if (cmd_reg == `DTCL_SLOT_CP)
                st_nxt.sw_data = {14'h0000, cmd_pci,
                                  cmd_data[`DTCL_ADDR_W-1:0]};
            else
                st_nxt.sw_data = cmd_data;
        end
        // Preloading blocks; this end never refuses a write
        if (mem_wr)
            st_nxt.mem[mem_wr_addr] = mem_wr_data;
        // One read in flight at most, answered on the next edge
        if (bus.mem_req) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = st_r.mem[rel_c[AW-1:0]];
        end
        // Interrupts are kept until reset so the user side cannot miss them
        st_nxt.irq_seen = st_r.irq_seen | bus.irq;
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign bus.sw_wr      = st_r.sw_wr;
    assign bus.sw_ch      = st_r.sw_ch;
    assign bus.sw_reg     = st_r.sw_reg;
    assign bus.sw_data    = st_r.sw_data;
    assign bus.mem_rvalid = st_r.rvalid;
    assign bus.mem_rdata  = st_r.rdata;
    assign irq_seen       = st_r.irq_seen;

endmodule

// ==== dv/dtcl_monitor.sv ====
// Checker on the carrier between the loader and the software end
`timescale 1ns/10ps
module dtcl_monitor #(
    parameter int NCH = 10,
    parameter int CW  = 4
) (
    input wire logic           clk,
    input wire logic           rst_b,
    input wire logic           sw_wr,
    input wire logic [CW-1:0]  sw_ch,
    input wire logic [3:0]     sw_reg,
    input wire logic [31:0]    sw_data,
    input wire logic           mem_req,
    input wire logic [17:0]    mem_addr,
    input wire logic           mem_rvalid,
    input wire logic [31:0]    mem_rdata,
    input wire logic [NCH-1:0] irq
);
    // One clock domain, so one clocking and one disable for all
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Each block word is its own single request
    req_pulse_a: assert property (mem_req |=> !mem_req)
        else $error("memory request longer than one cycle");
    answer_lat_a: assert property (mem_req |=> mem_rvalid)
        else $error("memory answer not one cycle after request");
    answer_cause_a: assert property (mem_rvalid |-> $past(mem_req))
        else $error("memory answer without request");
    // No second word while one is in flight
    in_flight_a: assert property (mem_rvalid |-> !mem_req)
        else $error("request issued while a word is in flight");
    // The 17-bit field plus the fixed offset always lands above the offset
    addr_offset_a: assert property (mem_req |-> mem_addr[17])
        else $error("fetch address lacks memory offset");
    addr_hold_a: assert property (!mem_req |-> $stable(mem_addr))
        else $error("fetch address moved without request");
    cp_pad_a: assert property (sw_wr && sw_reg == 4'h3 |-> sw_data[31:18] == 14'h0)
        else $error("pointer write wider than eighteen bits");
    irq_pulse_a: assert property ((irq & $past(irq)) == '0)
        else $error("interrupt held longer than one cycle");
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench joining loader and software end
`timescale 1ns/10ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    import dtcl_pkg::*;
    logic        clk, rst_b, mesh, cmd_valid, cmd_pci, mem_wr;
    logic [9:0]  seq_done, xfer_req, two_d_en, link_tx, xfer_gnt, chan_active, irq_seen;
    logic [3:0]  rd_ch, rd_slot, cmd_ch, cmd_reg;
    logic [31:0] rd_data, cmd_data, mem_wr_data;
    logic [7:0]  mem_wr_addr;
    logic        loading;
    logic [17:0] addrs[$];      // Fetch addresses seen on the carrier
    int          num_errors, n_compared;

    dtcl_if #(.NCH(10), .CW(4)) bus();
    dtcl_loader u_dtcl_loader (.clk(clk), .rst_b(rst_b), .bus(bus), .seq_done(seq_done),
        .xfer_req(xfer_req), .two_d_en(two_d_en), .link_tx(link_tx),
        .mesh_route_enable(mesh), .rd_ch(rd_ch), .rd_slot(rd_slot), .xfer_gnt(xfer_gnt),
        .chan_active(chan_active), .loading(loading), .rd_data(rd_data));
    dtcl_soft u_dtcl_soft (.clk(clk), .rst_b(rst_b), .bus(bus), .cmd_valid(cmd_valid),
        .cmd_ch(cmd_ch), .cmd_reg(cmd_reg), .cmd_data(cmd_data), .cmd_pci(cmd_pci),
        .mem_wr(mem_wr), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
        .irq_seen(irq_seen));
    dtcl_monitor u_dtcl_monitor (.clk(clk), .rst_b(rst_b), .sw_wr(bus.sw_wr),
        .sw_ch(bus.sw_ch), .sw_reg(bus.sw_reg), .sw_data(bus.sw_data),
        .mem_req(bus.mem_req), .mem_addr(bus.mem_addr), .mem_rvalid(bus.mem_rvalid),
        .mem_rdata(bus.mem_rdata), .irq(bus.irq));

    // 250 MHz clock
    always #2 clk = ~clk;
    // Sampled on the falling edge, clear of the flops' updates
    always @(negedge clk) begin
        if (bus.mem_req === 1'b1) begin
            addrs.push_back(bus.mem_addr);
        end
    end

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One software register write, forwarded to the loader next edge
    task automatic cmd(input logic [3:0] ch, input logic [3:0] rg, input logic [31:0] d);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_ch    <= ch;
        cmd_reg   <= rg;
        cmd_data  <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask

    // Block of n words below top; word 3 holds the next pointer
    task automatic blk(input logic [7:0] top, input int n, input logic [31:0] nxt);
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            mem_wr      <= 1'b1;
            mem_wr_addr <= top - 8'(k);
            mem_wr_data <= (k == 3) ? nxt : {top, 24'(k)};
        end
        @(posedge clk);
        mem_wr <= 1'b0;
    endtask

    // Enables first, then the pointer, with an edge between
    task automatic start(input logic [3:0] ch, input logic [7:0] top);
        cmd(ch, 4'ha, 32'h3);
        cmd(ch, 4'h3, {24'h0, top});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Bounded wait for a channel to run with no fetch going on
    task automatic wait_act(input int ch);
        int i;
        i = 0;
        do begin
            idle(1);
            i++;
            `CHK(xfer_gnt & ~chan_active, 10'h0)
        end while (!(chan_active[ch] === 1'b1 && loading === 1'b0) && i < 200);
        if (i >= 200) begin
            num_errors++;
            $display("ERROR at %0t: wait timed out", $time);
            wrap_up();
        end
    endtask

    task automatic rdc(input logic [3:0] ch, input logic [3:0] sl, input logic [31:0] e);
        @(posedge clk);
        rd_ch   <= ch;
        rd_slot <= sl;
        idle(1);
        `CHK(rd_data, e)
    endtask

    // Fetch order: top word first, then downward, offset added
    task automatic chk_addrs(input logic [7:0] top, input int n);
        logic [17:0] a;
        `CHK(addrs.size() >= n, 1'b1)
        for (int k = 0; k < n && addrs.size() > 0; k++) begin
            a = addrs.pop_front();
            `CHK(a, 18'h20000 + {10'h0, top} - 18'(k))
        end
    endtask

    task automatic done(input int ch);
        @(posedge clk);
        seq_done <= 10'h1 << ch;
        @(posedge clk);
        seq_done <= 10'h0;
    endtask

    initial begin
        {clk, mesh, cmd_valid, cmd_pci, mem_wr, seq_done, xfer_req} = '0;
        {two_d_en, link_tx, rd_ch, rd_slot, cmd_ch, cmd_reg, cmd_data} = '0;
        {mem_wr_data, mem_wr_addr, num_errors, n_compared, rst_b} = '0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rdc(4'h0, 4'h0, 32'h0);
        rdc(4'h0, 4'hf, 32'h0);
        // Plain five-word block, next pointer zero with interrupt select
        blk(8'h40, 5, 32'h20000);
        xfer_req <= 10'h001;
        start(4'h0, 8'h40);
        wait_act(0);
        `CHK(xfer_gnt[0], 1'b1)
        chk_addrs(8'h40, 5);
        for (int k = 0; k < 5; k++) begin
            rdc(4'h0, 4'(k), (k == 3) ? 32'h20000 : {8'h40, 24'(k)});
        end
        @(posedge clk);
        xfer_req <= 10'h0;
        done(0);
        idle(30);
        `CHK(irq_seen[0], 1'b1)
        `CHK(addrs.size(), 0)
        $display("test chain_basic done");
        // Eight-word block that points back at itself
        blk(8'h80, 8, 32'h80);
        start(4'h6, 8'h80);
        wait_act(6);
        chk_addrs(8'h80, 8);
        rdc(4'h6, 4'h7, {8'h80, 24'h7});
        done(6);
        wait_act(6);
        chk_addrs(8'h80, 8);
        `CHK(irq_seen[6], 1'b0)
        cmd(4'h6, 4'ha, 32'h2);
        idle(2);
        `CHK(chan_active[6], 1'b1)
        done(6);
        idle(30);
        `CHK(irq_seen[6], 1'b1)
        `CHK(addrs.size(), 0)
        // Subchain whose last pointer word leads back into the old loop
        blk(8'h50, 8, 32'h80);
        start(4'h6, 8'h50);
        wait_act(6);
        chk_addrs(8'h50, 8);
        done(6);
        wait_act(6);
        chk_addrs(8'h80, 8);
        $display("test loop_insert done");
        @(posedge clk);
        // Second dimension on channel 1, mesh routes on channel 2
        two_d_en <= 10'h002;
        link_tx  <= 10'h004;
        mesh     <= 1'b1;
        blk(8'h20, 6, 32'h0);
        blk(8'h60, 9, 32'h0);
        start(4'h1, 8'h20);
        wait_act(1);
        chk_addrs(8'h20, 6);
        rdc(4'h1, 4'h9, {8'h20, 24'h2});
        start(4'h2, 8'h60);
        wait_act(2);
        chk_addrs(8'h60, 9);
        rdc(4'h2, 4'h8, {8'h60, 24'h8});
        rdc(4'h2, 4'h5, 32'h0);
        $display("test two_d_mesh done");
        // Lowest priority starts; the two waiting go highest first
        blk(8'ha0, 5, 32'h0);
        blk(8'hc0, 5, 32'h0);
        blk(8'he0, 5, 32'h0);
        for (int c = 5; c > 2; c--) begin
            cmd(4'(c), 4'ha, 32'h3);
        end
        cmd(4'h5, 4'h3, 32'ha0);
        cmd(4'h4, 4'h3, 32'hc0);
        cmd(4'h3, 4'h3, 32'he0);
        wait_act(4);
        chk_addrs(8'ha0, 5);
        chk_addrs(8'he0, 5);
        chk_addrs(8'hc0, 5);
        $display("test priority done");
        // Junk above the address field is cleared; a zero address starts nothing
        cmd(4'h7, 4'ha, 32'h3);
        cmd_pci <= 1'b1;
        cmd(4'h7, 4'h3, 32'hfffc_0000);
        cmd_pci <= 1'b0;
        idle(4);
        `CHK(loading, 1'b0)
        `CHK(addrs.size(), 0)
        rdc(4'h7, 4'h3, 32'h0002_0000);
        $display("test pointer_write done");
        wrap_up();
    end
endmodule
